// ==== hdl/asb_pkg.sv ====
// Operation
// - sixteen twelve-bit result entries, each read in one of four 16-bit formats
// - software cannot write result entries; only conversions load them
// - a rising sample-start bit begins acquisition of the selected input
// - acquisition ends and conversion starts on soft, timer or external trigger
// - every conversion is stored; done and irq flags set after programmed count
// - four-bit samples-per-irq field selects 1 to 16 sequences per interrupt
// - split mode uses two eight-entry halves, swapped at every interrupt
// - split with field 0111: eight results per half, interrupt, then other half
// - unsplit mode places up to sixteen conversions per interrupt in whole buffer
// - alternate bit clear: only first input group is sampled
// - alternate bit set: first group, then second group, alternating from first
// - scan enable steps first-group input through inputs selected in scan mask
// - scan runs low to high and restarts from lowest after each interrupt
// - selected inputs beyond the samples per interrupt are never converted
// - results from inputs 13 to 15 are stored as a zero code (signed formats read it as 0xF800 or 0x8000)
package asb_pkg;
  localparam int          RES_W        = 12;
  localparam int          OUT_W        = 16;
  localparam int          N_ENTRIES    = 16;
  localparam int          N_CH         = 16;
  localparam logic [3:0]  PHANTOM_CH   = 4'hd;
  localparam logic [1:0]  TRIG_SOFT    = 2'h0;
  localparam logic [1:0]  TRIG_TIMER   = 2'h1;
  localparam logic [1:0]  TRIG_EXT     = 2'h2;
  localparam logic [1:0]  FMT_UINT     = 2'h0;
  localparam logic [1:0]  FMT_SINT     = 2'h1;
  localparam logic [1:0]  FMT_UFRAC    = 2'h2;
  localparam logic [1:0]  FMT_SFRAC    = 2'h3;
  localparam logic [3:0]  RST_CNT      = 4'h0;
  localparam logic [3:0]  RST_CH       = 4'h0;
  localparam logic [11:0] RST_RES      = 12'h000;
  localparam logic [15:0] RST_OUT      = 16'h0000;
  localparam int          FIFO_DEPTH   = 16;

  typedef enum logic [1:0] {
    ASB_IDLE    = 2'b00,
    ASB_SAMPLE  = 2'b01,
    ASB_CONVERT = 2'b11
  } asb_state_t;
endpackage : asb_pkg

// ==== hdl/asb_top.sv ====
`timescale 1ns/100ps
module asb_fifo #(
  parameter int W     = 16,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // fill side
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  // drain side
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;
  logic [AW:0]  next_wr_ptr;
  logic [AW:0]  next_rd_ptr;
  logic         push;
  logic         pop;

  assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_valid = (wr_ptr != rd_ptr);
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule : asb_fifo

module asb_top
  import asb_pkg::*;
#(
  parameter int FIFO_W = OUT_W,
  parameter int FIFO_D = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // sequencing control
  input  wire logic        module_enable,
  input  wire logic        sample_start_bit,
  input  wire logic [1:0]  trigger_select,
  input  wire logic        soft_convert,
  input  wire logic        timer_timeout,
  input  wire logic        ext_trigger_pin,
  // sequence configuration
  input  wire logic [3:0]  samples_per_irq_field,
  input  wire logic        buffer_split_bit,
  input  wire logic        alternate_input_bit,
  input  wire logic        scan_enable_bit,
  input  wire logic [15:0] scan_select_reg,
  input  wire logic [3:0]  first_input_group,
  input  wire logic [3:0]  second_input_group,
  input  wire logic [1:0]  result_format,
  // flags
  input  wire logic        done_clear,
  input  wire logic        irq_flag_clear,
  input  wire logic        converter_irq_enable,
  output logic             done_flag,
  output logic             converter_irq_flag,
  output logic             converter_irq,
  output logic             buffer_half,
  // analog core
  output logic             acquiring,
  output logic             conv_start,
  output logic [3:0]       conv_channel,
  input  wire logic        conv_result_valid,
  input  wire logic [11:0] conv_result,
  // result buffer read
  input  wire logic [3:0]  rd_addr,
  output logic [15:0]      rd_data,
  // result stream
  output logic             stream_valid,
  input  wire logic        stream_ready,
  output logic [FIFO_W-1:0] stream_data
);
  // lowest selected input at or above start, else lowest overall
  function automatic logic [3:0] scan_pick(input logic [15:0] mask, input logic [4:0] start);
    logic [3:0] pick;
    logic       hit;
    pick = RST_CH;
    hit  = 1'b0;
    for (int i = N_CH - 1; i >= 0; i--) begin
      if (mask[i] && (5'(i) >= start)) begin
        pick = 4'(i);
        hit  = 1'b1;
      end
    end
    if (!hit) begin
      for (int i = N_CH - 1; i >= 0; i--) begin
        if (mask[i]) begin
          pick = 4'(i);
        end
      end
    end
    return pick;
  endfunction : scan_pick

  function automatic logic [15:0] fmt(input logic [11:0] d, input logic [1:0] mode);
    logic [15:0] r;
    case (mode)
      FMT_UINT:  r = {4'h0, d};
      FMT_SINT:  r = {{5{~d[11]}}, d[10:0]};
      FMT_UFRAC: r = {d, 4'h0};
      FMT_SFRAC: r = {~d[11], d[10:0], 4'h0};
      default:   r = {4'h0, d};
    endcase
    return r;
  endfunction : fmt

  // external trigger synchroniser
  logic ext_meta;
  logic ext_sync;
  logic ext_prev;
  logic ext_rise;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ext_meta <= 1'b0;
      ext_sync <= 1'b0;
      ext_prev <= 1'b0;
    end else begin
      ext_meta <= ext_trigger_pin;
      ext_sync <= ext_meta;
      ext_prev <= ext_sync;
    end
  end

  assign ext_rise = ext_sync && !ext_prev;

  // sequencing state
  asb_state_t  state;
  asb_state_t  next_state;
  logic        start_prev;
  logic [3:0]  sample_cnt;
  logic [3:0]  next_sample_cnt;
  logic        half;
  logic        next_half;
  logic        alt_phase;
  logic        next_alt_phase;
  logic [3:0]  scan_ch;
  logic [3:0]  next_scan_ch;
  logic        cur_is_a;
  logic        next_cur_is_a;
  logic        next_done;
  logic        next_irq_flag;
  logic        next_conv_start;
  logic [3:0]  next_conv_channel;
  logic        start_rise;
  logic        trig_hit;
  logic        store;
  logic        batch_end;
  logic [3:0]  sel_ch;
  logic [3:0]  wr_addr;
  logic [11:0] wr_val;
  logic        fifo_ready;

  assign start_rise = sample_start_bit && !start_prev;
  assign store      = (state == ASB_CONVERT) && conv_result_valid;
  assign batch_end  = store && (sample_cnt == samples_per_irq_field);

  always_comb begin
    case (trigger_select)
      TRIG_SOFT:  trig_hit = soft_convert;
      TRIG_TIMER: trig_hit = timer_timeout;
      TRIG_EXT:   trig_hit = ext_rise;
      default:    trig_hit = 1'b0;
    endcase
  end

  always_comb begin
    if (alternate_input_bit && alt_phase) begin
      sel_ch = second_input_group;
    end else if (scan_enable_bit) begin
      sel_ch = scan_pick(scan_select_reg, {1'b0, scan_ch});
    end else begin
      sel_ch = first_input_group;
    end
  end

  always_comb begin
    if (buffer_split_bit) begin
      wr_addr = {half, sample_cnt[2:0]};
    end else begin
      wr_addr = sample_cnt;
    end
    wr_val = (conv_channel >= PHANTOM_CH) ? RST_RES : conv_result;
  end

  always_comb begin
    next_state        = state;
    next_sample_cnt   = sample_cnt;
    next_half         = half;
    next_alt_phase    = alt_phase;
    next_scan_ch      = scan_ch;
    next_cur_is_a     = cur_is_a;
    next_done         = done_flag;
    next_irq_flag     = converter_irq_flag;
    next_conv_start   = 1'b0;
    next_conv_channel = conv_channel;
    if (done_clear) begin
      next_done = 1'b0;
    end
    if (irq_flag_clear) begin
      next_irq_flag = 1'b0;
    end
    case (state)
      ASB_IDLE: begin
        if (module_enable && start_rise) begin
          next_state = ASB_SAMPLE;
          next_done  = 1'b0;
        end
      end
      ASB_SAMPLE: begin
        if (!module_enable) begin
          next_state = ASB_IDLE;
        end else if (trig_hit && fifo_ready) begin
          next_state        = ASB_CONVERT;
          next_conv_start   = 1'b1;
          next_conv_channel = sel_ch;
          next_cur_is_a     = !(alternate_input_bit && alt_phase);
        end
      end
      ASB_CONVERT: begin
        if (store) begin
          next_state      = ASB_IDLE;
          next_alt_phase  = alternate_input_bit && !alt_phase;
          next_sample_cnt = sample_cnt + 4'h1;
          if (scan_enable_bit && cur_is_a) begin
            next_scan_ch = scan_pick(scan_select_reg, 5'(conv_channel) + 5'h1);
          end
          if (batch_end) begin
            next_done       = 1'b1;
            next_irq_flag   = 1'b1;
            next_sample_cnt = RST_CNT;
            next_alt_phase  = 1'b0;
            next_scan_ch    = scan_pick(scan_select_reg, 5'h0);
            next_half       = buffer_split_bit && !half;
          end
        end
      end
      default: begin
        next_state = ASB_IDLE;
      end
    endcase
    if (state == ASB_IDLE && !module_enable) begin
      next_scan_ch    = scan_pick(scan_select_reg, 5'h0);
      next_sample_cnt = RST_CNT;
      next_alt_phase  = 1'b0;
      next_half       = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state              <= ASB_IDLE;
      start_prev         <= 1'b0;
      sample_cnt         <= RST_CNT;
      half               <= 1'b0;
      alt_phase          <= 1'b0;
      scan_ch            <= RST_CH;
      cur_is_a           <= 1'b1;
      done_flag          <= 1'b0;
      converter_irq_flag <= 1'b0;
      conv_start         <= 1'b0;
      conv_channel       <= RST_CH;
    end else begin
      state              <= next_state;
      start_prev         <= sample_start_bit;
      sample_cnt         <= next_sample_cnt;
      half               <= next_half;
      alt_phase          <= next_alt_phase;
      scan_ch            <= next_scan_ch;
      cur_is_a           <= next_cur_is_a;
      done_flag          <= next_done;
      converter_irq_flag <= next_irq_flag;
      conv_start         <= next_conv_start;
      conv_channel       <= next_conv_channel;
    end
  end

  assign acquiring     = (state == ASB_SAMPLE);
  assign converter_irq = converter_irq_flag && converter_irq_enable;
  assign buffer_half   = half;

  // result buffer: loaded only by the conversion path, no software write port
  logic [RES_W-1:0] result_buf [N_ENTRIES];
  logic [15:0]      next_rd_data;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < N_ENTRIES; i++) begin
        result_buf[i] <= RST_RES;
      end
    end else if (store) begin
      result_buf[wr_addr] <= wr_val;
    end
  end

  always_comb begin
    next_rd_data = fmt(result_buf[rd_addr], result_format);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= RST_OUT;
    end else begin
      rd_data <= next_rd_data;
    end
  end

  // every stored result is also streamed; a full fifo holds off the next trigger
  asb_fifo #(
    .W     (FIFO_W),
    .DEPTH (FIFO_D)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (store),
    .in_ready  (fifo_ready),
    .in_data   (FIFO_W'({conv_channel, wr_val})),
    .out_valid (stream_valid),
    .out_ready (stream_ready),
    .out_data  (stream_data)
  );
endmodule : asb_top

// ==== sim/asb_checker.sv ====
`timescale 1ns/100ps
module asb_checker
  import asb_pkg::*;
(
  // clock and reset
  input wire logic       clk,
  input wire logic       rst_n,
  // watched ports
  input wire logic       sample_start_bit,
  input wire logic       module_enable,
  input wire logic [1:0] trigger_select,
  input wire logic       soft_convert,
  input wire logic       conv_result_valid,
  input wire logic       done_clear,
  input wire logic       converter_irq_enable,
  input wire logic       done_flag,
  input wire logic       converter_irq_flag,
  input wire logic       converter_irq,
  input wire logic       acquiring,
  input wire logic       conv_start,
  input wire logic       stream_valid
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // soft trigger while sampling, fifo empty so never refused
  sequence soft_trig_s;
    acquiring && trigger_select == TRIG_SOFT && soft_convert && !stream_valid;
  endsequence
  sequence batch_end_s;
    $rose(done_flag);
  endsequence
  start_acq_a: assert property ($rose(acquiring) |-> $past(sample_start_bit) && module_enable)
    else $error("acquiring without start");
  soft_trig_a: assert property (soft_trig_s |=> conv_start)
    else $error("soft trigger lost");
  idle_trig_a: assert property (!acquiring |=> !conv_start)
    else $error("conversion outside sampling");
  conv_pulse_a: assert property (conv_start |=> !conv_start ##1 !conv_start)
    else $error("conv start too long");
  done_src_a: assert property (batch_end_s |-> $past(conv_result_valid) && converter_irq_flag)
    else $error("done without conversion");
  done_hold_a: assert property (done_flag && !done_clear && !$rose(sample_start_bit) |=> done_flag)
    else $error("done dropped");
  irq_mask_a: assert property (converter_irq == (converter_irq_flag && converter_irq_enable))
    else $error("irq mask wrong");
  push_src_a: assert property ($rose(stream_valid) |-> $past(conv_result_valid))
    else $error("stream word from nowhere");
endmodule : asb_checker

bind asb_top asb_checker u_asb_checker (.clk, .rst_n, .sample_start_bit, .module_enable,
  .trigger_select, .soft_convert, .conv_result_valid, .done_clear, .converter_irq_enable,
  .done_flag, .converter_irq_flag, .converter_irq, .acquiring, .conv_start, .stream_valid);

// ==== sim/asb_top_tb.sv ====
`timescale 1ns/100ps
module asb_top_tb;
  import asb_pkg::*;
  // stimulus
  logic        clk, rst_n, module_enable, sample_start_bit, soft_convert, timer_timeout;
  logic        ext_trigger_pin, buffer_split_bit, alternate_input_bit, scan_enable_bit;
  logic        done_clear, irq_flag_clear, converter_irq_enable, conv_result_valid;
  logic        stream_ready;
  logic [1:0]  trigger_select, result_format;
  logic [3:0]  samples_per_irq_field, first_input_group, second_input_group, rd_addr;
  logic [15:0] scan_select_reg;
  logic [11:0] conv_result;
  // observed
  logic        done_flag, converter_irq_flag, converter_irq, buffer_half, acquiring;
  logic        conv_start, stream_valid;
  logic [3:0]  conv_channel;
  logic [15:0] rd_data, stream_data;
  logic [15:0] fmt_exp [4] = '{16'h09a5, 16'h01a5, 16'h9a50, 16'h1a50};
  int          err_count, n_tests, i;

  asb_top u_asb_top (.clk, .rst_n, .module_enable, .sample_start_bit, .trigger_select,
    .soft_convert, .timer_timeout, .ext_trigger_pin, .samples_per_irq_field, .buffer_split_bit,
    .alternate_input_bit, .scan_enable_bit, .scan_select_reg, .first_input_group,
    .second_input_group, .result_format, .done_clear, .irq_flag_clear, .converter_irq_enable,
    .done_flag, .converter_irq_flag, .converter_irq, .buffer_half, .acquiring, .conv_start,
    .conv_channel, .conv_result_valid, .conv_result, .rd_addr, .rd_data, .stream_valid,
    .stream_ready, .stream_data);

  initial begin
    clk = 0;
    forever #50 clk = ~clk;
  end

  task automatic tick(int n = 1);
    repeat (n) @(posedge clk);
    #10;
  endtask : tick

  task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask : chk

  task automatic begin_sample;
    sample_start_bit = 1;
    tick(2);
    chk("acquiring", 1, acquiring);
    sample_start_bit = 0;
  endtask : begin_sample

  task automatic trig(logic [1:0] t, logic [3:0] ch);
    int k;
    trigger_select = t;
    soft_convert = (t == TRIG_SOFT);
    timer_timeout = (t == TRIG_TIMER);
    ext_trigger_pin = (t == TRIG_EXT);
    tick;
    soft_convert = 0;
    timer_timeout = 0;
    for (k = 0; k < 8 && conv_start !== 1; k++) tick;
    chk("conv_start", 1, conv_start);
    chk("channel", ch, conv_channel);
    ext_trigger_pin = 0;
  endtask : trig

  task automatic conv(logic [1:0] t, logic [11:0] r, logic [3:0] ch);
    begin_sample;
    trig(t, ch);
    conv_result = r;
    conv_result_valid = 1;
    tick;
    conv_result_valid = 0;
    tick;
  endtask : conv

  task automatic rd(logic [3:0] a, logic [15:0] e);
    rd_addr = a;
    tick;
    chk("rd_data", e, rd_data);
  endtask : rd

  task automatic clr(logic d, logic q);
    done_clear = d;
    irq_flag_clear = q;
    tick;
    done_clear = 0;
    irq_flag_clear = 0;
  endtask : clr

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  initial begin
    #(100 * 6000);
    err_count++;
    complete_run;
  end

  initial begin
    {rst_n, sample_start_bit, soft_convert, timer_timeout, ext_trigger_pin} = '0;
    {buffer_split_bit, scan_enable_bit, done_clear, irq_flag_clear, conv_result_valid} = '0;
    {trigger_select, result_format, rd_addr, scan_select_reg, conv_result} = '0;
    {module_enable, stream_ready, converter_irq_enable, alternate_input_bit} = '1;
    samples_per_irq_field = 4'h1;
    first_input_group = 4'h3;
    second_input_group = 4'h7;
    tick(12);
    rst_n = 1;
    chk("done", 0, done_flag);
    soft_convert = 1;
    tick;
    soft_convert = 0;
    chk("conv_start", 0, conv_start);
    conv(TRIG_SOFT, 12'h9a5, 4'h3);
    chk("done", 0, done_flag);
    conv(TRIG_TIMER, 12'h123, 4'h7);
    chk("done", 1, done_flag);
    chk("irq", 1, converter_irq);
    rd(4'h1, 16'h0123);
    for (i = 0; i < 4; i++) begin
      result_format = i[1:0];
      rd(4'h0, fmt_exp[i]);
    end
    result_format = FMT_UINT;
    clr(0, 1);
    chk("irq", 0, converter_irq);
    chk("done", 1, done_flag);
    conv(TRIG_EXT, 12'h456, 4'h3);
    chk("done", 0, done_flag);
    conv(TRIG_SOFT, 12'h789, 4'h7);
    rd(4'h0, 16'h0456);
    alternate_input_bit = 0;
    buffer_split_bit = 1;
    samples_per_irq_field = 4'h7;
    for (i = 0; i < 16; i++) begin
      conv(TRIG_SOFT, 12'h100 + i[11:0], 4'h3);
      chk("done", 16'(i % 8 == 7), done_flag);
      chk("half", 16'(i >= 7 && i < 15), buffer_half);
    end
    rd(4'h7, 16'h0107);
    rd(4'h8, 16'h0108);
    buffer_split_bit = 0;
    scan_enable_bit = 1;
    scan_select_reg = 16'h6024;
    samples_per_irq_field = 4'h2;
    converter_irq_enable = 0;
    clr(0, 1);
    conv(TRIG_SOFT, 12'h0aa, 4'h2);
    conv(TRIG_SOFT, 12'h0bb, 4'h5);
    chk("irq_flag", 0, converter_irq_flag);
    conv(TRIG_SOFT, 12'hfff, 4'hd);
    chk("irq", 0, converter_irq);
    chk("irq_flag", 1, converter_irq_flag);
    rd(4'h2, 16'h0000);
    conv(TRIG_SOFT, 12'h0cc, 4'h2);
    module_enable = 0;
    tick;
    module_enable = 1;
    scan_enable_bit = 0;
    samples_per_irq_field = 4'hf;
    clr(1, 1);
    converter_irq_enable = 1;
    stream_ready = 0;
    for (i = 0; i < 16; i++) conv(TRIG_SOFT, 12'h200 + i[11:0], 4'h3);
    chk("done", 1, done_flag);
    rd(4'hf, 16'h020f);
    begin_sample;
    soft_convert = 1;
    tick(3);
    soft_convert = 0;
    chk("acquiring", 1, acquiring);
    stream_ready = 1;
    for (i = 0; i < 16; i++) begin
      chk("stream", 16'h3200 + i[15:0], stream_data);
      tick;
    end
    chk("stream_valid", 0, stream_valid);
    trig(TRIG_SOFT, 4'h3);
    complete_run;
  end
endmodule : asb_top_tb
